/* rtl/tag_core_consts.svh */
// constants shared by the transponder core and its state machine
// assumes inclusion by bare name from files under rtl/
`ifndef TAG_CORE_CONSTS_SVH
`define TAG_CORE_CONSTS_SVH
`define PAGE_CNT    16
`define PG_WORDS    8
`define BLK_CNT     128
`define SCR_WORDS   8
`define LAST_BLK    7'h7f
`define LAST_SCR    7'h07
`define LAST_SER    7'h01
`define PROT_RP     0
`define PROT_WP     1
`define PROT_EP     2
`define PROT_AU     3
`define REG_STATUS  4'h0
`define REG_CTRL    4'h1
`define REG_PROT_LO 4'h2
`define REG_PROT_HI 4'h3
`define CTRL_RST    1'b1
`endif

/* rtl/tag_pkg.sv */
// types of the transponder core: request commands, protocol states, read sources
// assumes the frame decoder outside maps request codes onto cmd_type
package tag_pkg;
   typedef enum logic [4:0] {
      CMD_INVENTORY, CMD_STAY_QUIET, CMD_SELECT, CMD_RESET_READY, CMD_GET_INFO,
      CMD_READ_SINGLE, CMD_READ_MULTI, CMD_READ_MEM, CMD_WRITE_MEM, CMD_SET_PROT,
      CMD_READ_STATUS, CMD_WRITE_SCR, CMD_READ_SCR, CMD_LOAD_SECRET, CMD_READ_SERIAL,
      CMD_WRITE_AFI, CMD_LOCK_AFI, CMD_WRITE_DSFID
   } cmd_type;
   typedef enum logic [1:0] {ST_OFF, ST_READY, ST_QUIET, ST_SELECTED} xstate_type;
   typedef enum logic [1:0] {SRC_MEM, SRC_SCR, SRC_SER} src_type;
endpackage

/* rtl/tag_state_fsm.sv */
// protocol state tracker and address-mode request filter
// assumes field_i is already synchronised and uid_match_i is same-clock logic
`timescale 1ns/1ps
`include "tag_core_consts.svh"
module tag_state_fsm (
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            field_i,
   input  wire logic            req_valid_i,
   input  tag_pkg::cmd_type     req_cmd_i,
   input  wire logic            req_flag_addr_i,
   input  wire logic            req_flag_sel_i,
   input  wire logic            uid_match_i,
   output tag_pkg::xstate_type  state_o,
   output logic                 accept_o
);
   tag_pkg::xstate_type state_r;
   logic                adr_w;
   logic                non_w;
   logic                sel_w;

   // address mode from the two request flags
   assign adr_w = req_flag_addr_i && !req_flag_sel_i;
   assign non_w = !req_flag_addr_i && !req_flag_sel_i;
   assign sel_w = !req_flag_addr_i && req_flag_sel_i;
   assign state_o = state_r;

   // which requests the current state processes; addressed ones need our own uid
   always_comb begin
      case (state_r)
         tag_pkg::ST_READY:    accept_o = req_valid_i && (non_w || (adr_w && uid_match_i));
         tag_pkg::ST_QUIET:    accept_o = req_valid_i && adr_w && uid_match_i;
         tag_pkg::ST_SELECTED: accept_o = req_valid_i && (non_w || sel_w || (adr_w && uid_match_i));
         default:              accept_o = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // transitions; losing the field wipes everything back to power-off
   always_ff @(posedge clk_i) begin
      if (rst_i || !field_i) begin
         state_r <= tag_pkg::ST_OFF;
      end else if (state_r == tag_pkg::ST_OFF) begin
         state_r <= tag_pkg::ST_READY;
      end else if (req_valid_i) begin
         case (req_cmd_i)
            tag_pkg::CMD_STAY_QUIET: begin
               if (adr_w && uid_match_i) state_r <= tag_pkg::ST_QUIET;
            end
            tag_pkg::CMD_SELECT: begin
               if (adr_w && uid_match_i) state_r <= tag_pkg::ST_SELECTED;
               else if (adr_w && state_r == tag_pkg::ST_SELECTED) state_r <= tag_pkg::ST_READY;
            end
            // quiet wakes on a nonaddressed reset to ready even though it stays silent
            tag_pkg::CMD_RESET_READY: begin
               if ((accept_o && !sel_w) || non_w) state_r <= tag_pkg::ST_READY;
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_field_up;
      state_r == tag_pkg::ST_OFF && field_i |=> state_r == tag_pkg::ST_READY;
   endproperty
   a_field_up: assert property (p_field_up) else $error("no ready after field");

   property p_field_lost;
      !field_i |=> state_r == tag_pkg::ST_OFF;
   endproperty
   a_field_lost: assert property (p_field_lost) else $error("no power-off on field loss");

   property p_quiet_filter;
      state_r == tag_pkg::ST_QUIET && !adr_w |-> !accept_o;
   endproperty
   a_quiet_filter: assert property (p_quiet_filter) else $error("quiet took non-addressed");

   property p_ready_select;
      field_i && state_r == tag_pkg::ST_READY && req_valid_i && req_cmd_i == tag_pkg::CMD_SELECT
         && adr_w && uid_match_i |=> state_r == tag_pkg::ST_SELECTED;
   endproperty
   a_ready_select: assert property (p_ready_select) else $error("select missed");

   property p_sel_mismatch;
      field_i && state_r == tag_pkg::ST_SELECTED && req_valid_i && req_cmd_i == tag_pkg::CMD_SELECT
         && adr_w && !uid_match_i |=> state_r == tag_pkg::ST_READY;
   endproperty
   a_sel_mismatch: assert property (p_sel_mismatch) else $error("foreign select kept us");
endmodule

/* rtl/tag_core.sv */
// transponder memory and protocol core: user memory, protections, scratchpad,
// secret storage, identifier bytes and the word-stream response engine
// assumes a frame decoder that hands over one decoded request per strobe and
// takes one response word per valid cycle without back-pressure
`timescale 1ns/1ps
`include "tag_core_consts.svh"
module tag_core #(
   parameter logic [63:0] OWN_UID = 64'h1122334455667788, // arbitrary value
   parameter logic [63:0] SERIAL  = 64'h8877665544332211, // arbitrary value
   parameter logic [15:0] MFG_ID  = 16'h0000
) (
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            field_i,
   input  wire logic            req_valid_i,
   input  tag_pkg::cmd_type     req_cmd_i,
   input  wire logic            req_flag_addr_i,
   input  wire logic            req_flag_sel_i,
   input  wire logic [63:0]     req_uid_i,
   input  wire logic [6:0]      req_block_i,
   input  wire logic [6:0]      req_count_i,
   input  wire logic [31:0]     req_data_i,
   input  wire logic            req_mac_ok_i,
   input  wire logic [3:0]      bus_addr_i,
   input  wire logic [31:0]     bus_wdata_i,
   input  wire logic            bus_wr_i,
   input  wire logic            bus_rd_i,
   output logic [31:0]          bus_rdata_o,
   output logic                 rsp_valid_o,
   output logic                 rsp_err_o,
   output logic                 rsp_last_o,
   output logic [31:0]          rsp_data_o,
   output tag_pkg::xstate_type  state_o
);
   // storage; user memory and secret are nonvolatile and carry no reset
   logic [31:0]         user_mem [`BLK_CNT];
   logic [31:0]         secret_r [`SCR_WORDS];
   logic [31:0]         scratch_r [`SCR_WORDS];
   logic [3:0]          prot_r [`PAGE_CNT];
   logic [63:0]         prot_flat_w;
   logic                secret_lock_r;
   logic                afi_lock_r;
   logic [7:0]          afi_r;
   logic [7:0]          dsfid_r;
   logic                rf_en_r;
   logic                field_s1_r;
   logic                field_s2_r;
   logic                accept_w;
   logic                exec_w;
   logic [3:0]          page_w;
   logic                wr_ok_w;
   logic                prot_ok_w;
   logic [7:0]          multi_end_w;
   logic                range_bad_w;
   logic                rd_active_r;
   logic [6:0]          rd_ptr_r;
   logic [6:0]          rd_end_r;
   tag_pkg::src_type    rd_src_r;
   logic [31:0]         rd_word_w;
   logic                rd_blocked_w;
   logic                rd_done_w;
   logic                rsp_valid_r;
   logic                rsp_err_r;
   logic                rsp_last_r;
   logic [31:0]         rsp_data_r;
   logic [31:0]         bus_rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // field detect comes from the analog side, so it is synchronised first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         field_s1_r <= 1'b0;
         field_s2_r <= 1'b0;
      end else begin
         field_s1_r <= field_i;
         field_s2_r <= field_s1_r;
      end
   end

   tag_state_fsm u_fsm (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .field_i         (field_s2_r),
      .req_valid_i     (req_valid_i && rf_en_r),
      .req_cmd_i       (req_cmd_i),
      .req_flag_addr_i (req_flag_addr_i),
      .req_flag_sel_i  (req_flag_sel_i),
      .uid_match_i     (req_uid_i == OWN_UID),
      .state_o         (state_o),
      .accept_o        (accept_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // request decode; during a running read stream a request only reaches u_fsm for its state change and is not executed or answered
   assign exec_w      = accept_w && field_s2_r && !rd_active_r;
   assign page_w      = req_block_i[6:3];
   assign wr_ok_w     = !prot_r[page_w][`PROT_WP] && (!prot_r[page_w][`PROT_AU] || req_mac_ok_i);
   assign prot_ok_w   = !prot_r[page_w][`PROT_AU] || req_mac_ok_i;
   assign multi_end_w = {1'b0, req_block_i} + {1'b0, req_count_i};
   assign range_bad_w = multi_end_w > {1'b0, `LAST_BLK};

   // flat protection view for the wired status registers
   generate
      for (genvar g = 0; g < `PAGE_CNT; g++) begin : g_prot
         assign prot_flat_w[g*4 +: 4] = prot_r[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // user memory: whole 32-bit words only; eprom mode may only clear bits
   always_ff @(posedge clk_i) begin
      if (exec_w && req_cmd_i == tag_pkg::CMD_WRITE_MEM && wr_ok_w) begin
         if (prot_r[page_w][`PROT_EP]) begin
            user_mem[req_block_i] <= user_mem[req_block_i] & req_data_i;
         end else begin
            user_mem[req_block_i] <= req_data_i;
         end
      end
   end

   // protection bits only ever OR in; only rst_i clears them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `PAGE_CNT; i++) prot_r[i] <= 4'h0;
      end else if (exec_w && req_cmd_i == tag_pkg::CMD_SET_PROT && prot_ok_w) begin
         prot_r[page_w] <= prot_r[page_w] | req_data_i[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scratchpad is volatile and is lost with the field
   always_ff @(posedge clk_i) begin
      if (rst_i || !field_s2_r) begin
         for (int i = 0; i < `SCR_WORDS; i++) scratch_r[i] <= 32'h0;
      end else if (exec_w && req_cmd_i == tag_pkg::CMD_WRITE_SCR) begin
         scratch_r[req_block_i[2:0]] <= req_data_i;
      end
   end

   // secret is copied from the scratchpad in one go, never word by word
   always_ff @(posedge clk_i) begin
      if (exec_w && req_cmd_i == tag_pkg::CMD_LOAD_SECRET && !secret_lock_r) begin
         for (int i = 0; i < `SCR_WORDS; i++) secret_r[i] <= scratch_r[i];
      end
   end

   // locks and identifier bytes; req_data_i[0] asks to lock with the load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         secret_lock_r <= 1'b0;
         afi_lock_r    <= 1'b0;
         afi_r         <= 8'h00;
         dsfid_r       <= 8'h00;
      end else if (exec_w) begin
         case (req_cmd_i)
            tag_pkg::CMD_LOAD_SECRET: begin
               if (!secret_lock_r) secret_lock_r <= req_data_i[0];
            end
            tag_pkg::CMD_WRITE_AFI: begin
               if (!afi_lock_r) afi_r <= req_data_i[7:0];
            end
            tag_pkg::CMD_LOCK_AFI:    afi_lock_r <= 1'b1;
            tag_pkg::CMD_WRITE_DSFID: dsfid_r <= req_data_i[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stream source; secret_r has no route here by construction
   always_comb begin
      case (rd_src_r)
         tag_pkg::SRC_MEM: rd_word_w = user_mem[rd_ptr_r];
         tag_pkg::SRC_SCR: rd_word_w = scratch_r[rd_ptr_r[2:0]];
         tag_pkg::SRC_SER: rd_word_w = rd_ptr_r[0] ? SERIAL[63:32] : SERIAL[31:0];
         default:          rd_word_w = 32'h0;
      endcase
   end
   assign rd_blocked_w = rd_src_r == tag_pkg::SRC_MEM && prot_r[rd_ptr_r[6:3]][`PROT_RP];
   assign rd_done_w    = rd_blocked_w || rd_ptr_r == rd_end_r;

   // response engine: single answers one cycle after the request, streams
   // start two cycles after it; a read-protected page ends a stream with error
   always_ff @(posedge clk_i) begin
      if (rst_i || !field_s2_r) begin
         rd_active_r <= 1'b0;
         rd_ptr_r    <= 7'h00;
         rd_end_r    <= 7'h00;
         rd_src_r    <= tag_pkg::SRC_MEM;
         rsp_valid_r <= 1'b0;
         rsp_err_r   <= 1'b0;
         rsp_last_r  <= 1'b0;
         rsp_data_r  <= 32'h0;
      end else if (rd_active_r) begin
         rsp_valid_r <= 1'b1;
         rsp_err_r   <= rd_blocked_w;
         rsp_last_r  <= rd_done_w;
         rsp_data_r  <= rd_blocked_w ? 32'h0 : rd_word_w;
         rd_active_r <= !rd_done_w;
         rd_ptr_r    <= rd_ptr_r + 7'h01;
      end else if (exec_w) begin
         rsp_valid_r <= 1'b1;
         rsp_err_r   <= 1'b0;
         rsp_last_r  <= 1'b1;
         rsp_data_r  <= 32'h0;
         case (req_cmd_i)
            tag_pkg::CMD_STAY_QUIET: begin
               rsp_valid_r <= 1'b0;
               rsp_last_r  <= 1'b0;
            end
            tag_pkg::CMD_READ_SINGLE, tag_pkg::CMD_READ_MULTI, tag_pkg::CMD_READ_MEM: begin
               if (req_cmd_i == tag_pkg::CMD_READ_MULTI && range_bad_w) begin
                  rsp_err_r <= 1'b1;
               end else begin
                  rsp_valid_r <= 1'b0;
                  rsp_last_r  <= 1'b0;
                  rd_active_r <= 1'b1;
                  rd_src_r    <= tag_pkg::SRC_MEM;
                  rd_ptr_r    <= req_block_i;
                  if (req_cmd_i == tag_pkg::CMD_READ_SINGLE) rd_end_r <= req_block_i;
                  else if (req_cmd_i == tag_pkg::CMD_READ_MULTI) rd_end_r <= multi_end_w[6:0];
                  else rd_end_r <= `LAST_BLK;
               end
            end
            tag_pkg::CMD_READ_SCR, tag_pkg::CMD_READ_SERIAL: begin
               rsp_valid_r <= 1'b0;
               rsp_last_r  <= 1'b0;
               rd_active_r <= 1'b1;
               rd_ptr_r    <= 7'h00;
               if (req_cmd_i == tag_pkg::CMD_READ_SCR) begin
                  rd_src_r <= tag_pkg::SRC_SCR;
                  rd_end_r <= `LAST_SCR;
               end else begin
                  rd_src_r <= tag_pkg::SRC_SER;
                  rd_end_r <= `LAST_SER;
               end
            end
            tag_pkg::CMD_WRITE_MEM:   rsp_err_r <= !wr_ok_w;
            tag_pkg::CMD_SET_PROT:    rsp_err_r <= !prot_ok_w;
            tag_pkg::CMD_LOAD_SECRET: rsp_err_r <= secret_lock_r;
            tag_pkg::CMD_WRITE_AFI:   rsp_err_r <= afi_lock_r;
            tag_pkg::CMD_READ_STATUS: rsp_data_r <= {MFG_ID, 7'h00, secret_lock_r, 4'h0, prot_r[page_w]};
            tag_pkg::CMD_GET_INFO, tag_pkg::CMD_INVENTORY: rsp_data_r <= {16'h0000, dsfid_r, afi_r};
            default: ;
         endcase
      end else begin
         rsp_valid_r <= 1'b0;
         rsp_err_r   <= 1'b0;
         rsp_last_r  <= 1'b0;
      end
   end

   assign rsp_valid_o = rsp_valid_r;
   assign rsp_err_o   = rsp_err_r;
   assign rsp_last_o  = rsp_last_r;
   assign rsp_data_o  = rsp_data_r;

   ////////////////////////////////////////////////////////////////////////////
   // wired register port; identifier bytes are deliberately not mapped here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rf_en_r <= `CTRL_RST;
      end else if (bus_wr_i && bus_addr_i == `REG_CTRL) begin
         rf_en_r <= bus_wdata_i[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !bus_rd_i) begin
         bus_rdata_r <= 32'h0;
      end else begin
         case (bus_addr_i)
            `REG_STATUS:  bus_rdata_r <= {28'h0, secret_lock_r, afi_lock_r, state_o};
            `REG_CTRL:    bus_rdata_r <= {31'h0, rf_en_r};
            `REG_PROT_LO: bus_rdata_r <= prot_flat_w[31:0];
            `REG_PROT_HI: bus_rdata_r <= prot_flat_w[63:32];
            default:      bus_rdata_r <= 32'h0;
         endcase
      end
   end
   assign bus_rdata_o = bus_rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_word_more;
      rsp_valid_o && !rsp_last_o && !rsp_err_o;
   endsequence
   sequence s_word_last;
      rsp_valid_o && rsp_last_o && !rsp_err_o;
   endsequence

   property p_quiet_silent;
      exec_w && req_cmd_i == tag_pkg::CMD_STAY_QUIET |=> !rsp_valid_o ##1 !rsp_valid_o;
   endproperty
   a_quiet_silent: assert property (p_quiet_silent) else $error("stay quiet answered");

   property p_auth_refuse;
      exec_w && req_cmd_i == tag_pkg::CMD_WRITE_MEM && prot_r[page_w][`PROT_AU] && !req_mac_ok_i
         |=> rsp_valid_o && rsp_err_o;
   endproperty
   a_auth_refuse: assert property (p_auth_refuse) else $error("auth page write not refused");

   property p_prot_sticky;
      (prot_flat_w & $past(prot_flat_w)) == $past(prot_flat_w);
   endproperty
   a_prot_sticky: assert property (p_prot_sticky) else $error("protection bit cleared");

   property p_range_err;
      exec_w && req_cmd_i == tag_pkg::CMD_READ_MULTI && range_bad_w |=> rsp_valid_o && rsp_err_o && rsp_last_o;
   endproperty
   a_range_err: assert property (p_range_err) else $error("overrange read not rejected");

   property p_secret_locked;
      exec_w && req_cmd_i == tag_pkg::CMD_LOAD_SECRET && secret_lock_r |=> rsp_err_o && secret_lock_r;
   endproperty
   a_secret_locked: assert property (p_secret_locked) else $error("locked secret accepted");

   property p_serial_read;
      exec_w && req_cmd_i == tag_pkg::CMD_READ_SERIAL && field_s2_r
         |=> !rsp_valid_o ##1 (s_word_more and rsp_data_o == SERIAL[31:0]) ##1 s_word_last;
   endproperty
   a_serial_read: assert property (p_serial_read) else $error("serial stream wrong");
endmodule

/* tb/reader_model.sv */
// reader side of the core: presents one decoded request per call of send
// assumes send is entered just after a rising edge of clk_i
`timescale 1ns/1ps
module reader_model (
   input  wire logic         clk_i,
   output logic              valid_o,
   output tag_pkg::cmd_type  cmd_o,
   output logic              addr_o,
   output logic              sel_o,
   output logic [63:0]       uid_o,
   output logic [6:0]        blk_o,
   output logic [6:0]        cnt_o,
   output logic [31:0]       data_o,
   output logic              mac_o
);
   //////////////////////////////////////////////////////////////////////
   // idle lines start at known values
   initial begin
      valid_o = 1'b0;
      cmd_o = tag_pkg::CMD_INVENTORY;
      {addr_o, sel_o, uid_o, blk_o, cnt_o, data_o, mac_o} = '0;
   end
   // mode 0 nonaddressed, 1 addressed, 2 select, 3 addressed to another uid
   task automatic send(input tag_pkg::cmd_type c, input int m, input logic [63:0] u,
                       input logic [6:0] b, input logic [6:0] n, input logic [31:0] d, input logic k);
      valid_o <= 1'b1;
      cmd_o <= c;
      addr_o <= (m == 1 || m == 3);
      sel_o <= (m == 2);
      uid_o <= (m == 3) ? ~u : u;
      blk_o <= b;
      cnt_o <= n;
      data_o <= d;
      mac_o <= k;
      @(posedge clk_i);
      valid_o <= 1'b0;
      // released uid, data and block lines stop showing the last value, so stale data cannot pass
      uid_o <= ~uid_o;
      data_o <= ~data_o;
      blk_o <= ~blk_o;
   endtask
endmodule

/* tb/tb_tag_core.sv */
// self-checking bench for the transponder core with a queue-based model
// assumes reader_model drives the request side and the bench the wired port
`timescale 1ns/1ps
`include "tag_core_consts.svh"
module tb_tag_core;
   localparam logic [63:0] UID = 64'h0a1b2c3d4e5f6071; // arbitrary value
   localparam logic [63:0] SER = 64'h5c4d3e2f1a0b9687; // arbitrary value
   logic clk_i, rst_i, field_i, bus_wr_i, bus_rd_i, mac_ok;
   logic [3:0] bus_addr_i;
   logic [31:0] bus_wdata_i, bus_rdata_o, rsp_data_o;
   logic rsp_valid_o, rsp_err_o, rsp_last_o, q_valid, q_addr, q_sel, q_mac;
   tag_pkg::cmd_type q_cmd;
   tag_pkg::xstate_type state_o;
   logic [63:0] q_uid;
   logic [6:0] q_blk, q_cnt;
   logic [31:0] q_data, mem [128], scr [8], exp_q [$], rnd;
   int seed, n_errors, check_count;
   //////////////////////////////////////////////////////////////////////
   reader_model rdr (.clk_i(clk_i), .valid_o(q_valid), .cmd_o(q_cmd), .addr_o(q_addr), .sel_o(q_sel),
      .uid_o(q_uid), .blk_o(q_blk), .cnt_o(q_cnt), .data_o(q_data), .mac_o(q_mac));
   tag_core #(.OWN_UID(UID), .SERIAL(SER), .MFG_ID(16'h0000)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .field_i(field_i), .req_valid_i(q_valid), .req_cmd_i(q_cmd), .req_flag_addr_i(q_addr),
      .req_flag_sel_i(q_sel), .req_uid_i(q_uid), .req_block_i(q_blk), .req_count_i(q_cnt),
      .req_data_i(q_data), .req_mac_ok_i(q_mac), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .rsp_valid_o(rsp_valid_o),
      .rsp_err_o(rsp_err_o), .rsp_last_o(rsp_last_o), .rsp_data_o(rsp_data_o), .state_o(state_o));
   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one wired-port cycle; for a read d is the expected value
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus_rd_i <= rd;
      bus_wr_i <= !rd;
      bus_addr_i <= a;
      bus_wdata_i <= d;
      @(posedge clk_i);
      bus_rd_i <= 1'b0;
      bus_wr_i <= 1'b0;
      #1;
      if (rd) chk("bus_rdata", d, bus_rdata_o);
   endtask
   // one request; the answer is compared with exp_q word by word in a bounded window
   task automatic req(input tag_pkg::cmd_type c, input int m, input logic [6:0] b, input logic [6:0] n,
                      input logic [31:0] d, input logic e);
      int w, nw;
      w = 0;
      nw = exp_q.size();
      @(posedge clk_i);
      rdr.send(c, m, UID, b, n, d, mac_ok);
      // single answers stand only in the cycle right after the request edge
      repeat (12) begin
         #1;
         if (rsp_valid_o === 1'b1) begin
            w++;
            chk("rsp_err", e, rsp_err_o);
            chk("rsp_data", exp_q.size() ? exp_q.pop_front() : 32'h0, rsp_data_o);
            chk("rsp_last", exp_q.size() == 0, rsp_last_o);
         end
         @(posedge clk_i);
      end
      chk("rsp_words", nw, w);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // main sequence: wired port, memory, scratchpad, protections, protocol states
   initial begin
      seed = 32'ha911f358;
      {n_errors, check_count} = '0;
      {rst_i, field_i, mac_ok} = 3'b111;
      {bus_wr_i, bus_rd_i, bus_addr_i, bus_wdata_i} = '0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("state", tag_pkg::ST_READY, state_o);
      bus(1'b1, `REG_CTRL, 32'h1);
      bus(1'b0, 4'h9, 32'hffffffff);
      bus(1'b1, 4'h9, 32'h0);
      exp_q = {SER[31:0], SER[63:32]};
      req(tag_pkg::CMD_READ_SERIAL, 0, 0, 0, 0, 0);
      foreach (mem[i]) if (i == 7 || i == 8 || i == 127) begin
         mem[i] = $random(seed);
         exp_q = {32'h0};
         req(tag_pkg::CMD_WRITE_MEM, 0, i, 0, mem[i], 0);
      end
      exp_q = {mem[7], mem[8]};
      req(tag_pkg::CMD_READ_MULTI, 0, 7, 1, 0, 0);
      exp_q = {mem[127]};
      req(tag_pkg::CMD_READ_SINGLE, 0, `LAST_BLK, 0, 0, 0);
      exp_q = {mem[127]};
      req(tag_pkg::CMD_READ_MEM, 0, `LAST_BLK, 0, 0, 0);
      // eprom mode on page 0: a write may only clear bits
      exp_q = {32'h0};
      req(tag_pkg::CMD_SET_PROT, 0, 0, 0, 32'h4, 0);
      rnd = $random(seed);
      mem[7] = mem[7] & rnd;
      exp_q = {32'h0};
      req(tag_pkg::CMD_WRITE_MEM, 0, 7, 0, rnd, 0);
      exp_q = {mem[7]};
      req(tag_pkg::CMD_READ_SINGLE, 0, 7, 0, 0, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_READ_MULTI, 0, `LAST_BLK, 1, 0, 1);
      foreach (scr[i]) begin
         scr[i] = $random(seed);
         exp_q = {32'h0};
         req(tag_pkg::CMD_WRITE_SCR, 0, i, 0, scr[i], 0);
      end
      foreach (scr[i]) exp_q.push_back(scr[i]);
      req(tag_pkg::CMD_READ_SCR, 0, 0, 0, 0, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_LOAD_SECRET, 0, 0, 0, 32'h1, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_LOAD_SECRET, 0, 0, 0, 32'h0, 1);
      bus(1'b1, `REG_STATUS, 32'h9);
      exp_q = {32'h0};
      req(tag_pkg::CMD_SET_PROT, 0, 8, 0, 32'h2, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_WRITE_MEM, 0, 8, 0, 32'h0, 1);
      exp_q = {32'h0};
      req(tag_pkg::CMD_SET_PROT, 0, 8, 0, 32'h0, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_SET_PROT, 0, 16, 0, 32'h8, 0);
      mac_ok = 1'b0;
      exp_q = {32'h0};
      req(tag_pkg::CMD_WRITE_MEM, 0, 16, 0, 32'h0, 1);
      mac_ok = 1'b1;
      exp_q = {32'h0};
      req(tag_pkg::CMD_SET_PROT, 0, 120, 0, 32'h1, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_READ_SINGLE, 0, `LAST_BLK, 0, 0, 1);
      bus(1'b1, `REG_PROT_LO, 32'h00000824);
      bus(1'b1, `REG_PROT_HI, 32'h10000000);
      exp_q = {32'h00000102};
      req(tag_pkg::CMD_READ_STATUS, 0, 8, 0, 0, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_WRITE_AFI, 0, 0, 0, 32'h5a, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_WRITE_DSFID, 0, 0, 0, 32'h3c, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_LOCK_AFI, 0, 0, 0, 0, 0);
      exp_q = {32'h0};
      req(tag_pkg::CMD_WRITE_AFI, 0, 0, 0, 32'h11, 1);
      exp_q = {32'h00003c5a};
      req(tag_pkg::CMD_GET_INFO, 0, 0, 0, 0, 0);
      bus(1'b1, `REG_STATUS, 32'hd);
      req(tag_pkg::CMD_STAY_QUIET, 1, 0, 0, 0, 0);
      chk("state", tag_pkg::ST_QUIET, state_o);
      exp_q = {};
      req(tag_pkg::CMD_READ_SERIAL, 0, 0, 0, 0, 0);
      // quiet gives no answer to a nonaddressed request, yet wakes up
      exp_q = {};
      req(tag_pkg::CMD_RESET_READY, 0, 0, 0, 0, 0);
      chk("state", tag_pkg::ST_READY, state_o);
      exp_q = {32'h0};
      req(tag_pkg::CMD_SELECT, 1, 0, 0, 0, 0);
      chk("state", tag_pkg::ST_SELECTED, state_o);
      exp_q = {SER[31:0], SER[63:32]};
      req(tag_pkg::CMD_READ_SERIAL, 2, 0, 0, 0, 0);
      exp_q = {32'h00003c5a};
      req(tag_pkg::CMD_INVENTORY, 2, 0, 0, 0, 0);
      req(tag_pkg::CMD_SELECT, 3, 0, 0, 0, 0);
      chk("state", tag_pkg::ST_READY, state_o);
      field_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("state", tag_pkg::ST_OFF, state_o);
      field_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("state", tag_pkg::ST_READY, state_o);
      finish_test();
   end
endmodule
